// file: fpmd_pkg.sv
// constants, operation codes and state codes of the fixed-point mul/div unit
// Operation
// [RQ1] negatives are two's complement; subtraction adds the subtrahend's two's complement
// [RQ2] two's complement is formed by inverting all bits and adding one
// [RQ3] multiplier scanned right to left; groups of ones open on 11, close on 00
// [RQ4] multiplier one: subtract if group starts, shift inside group, add if isolated
// [RQ5] multiplier zero: subtract inside group, add when ending group, else shift
// [RQ6] division is repeated reduction; same sign as dividend gives quotient one
// [RQ7] opposite sign after reduction is an overdraw; no quotient one for it
// [RQ8] every overdraw is followed by adding the divisor back
// [RQ9] adder carry-out during reduction means positive result and quotient one
// [RQ10] each operand byte carries parity; an error only raises an interrupt request
// [RQ11] operand length implied by operation: 1, 2, 4 or 8 bytes, leftmost byte first; here size_in selects the length for every operation
// [RQ12] dividend shifts against divisor; correction merges with next reduction
// [RQ13] start pulse presents operands; result held, one-cycle done when ready
// [RQ14] reset clears accumulator, quotient and counter, returns idle until next start
package fpmd_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int DATA_W = 64;
  localparam int BYTES  = 8;
  localparam int ADD_W  = DATA_W + 2;
  localparam int CNT_W  = 7;

  // ----------------------------------------------------------------
  // operation and field length codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPMD_OP_ADD = 2'h0,
    FPMD_OP_SUB = 2'h1,
    FPMD_OP_MUL = 2'h2,
    FPMD_OP_DIV = 2'h3
  } fpmd_op_type;

  localparam logic [1:0] SIZE_BYTE   = 2'h0;
  localparam logic [1:0] SIZE_HALF   = 2'h1;
  localparam logic [1:0] SIZE_WORD   = 2'h2;
  localparam logic [1:0] SIZE_DOUBLE = 2'h3;

  // field length in bits for each size code; the left-alignment shift is 64 minus it
  localparam logic [CNT_W-1:0] BITS_BYTE   = 7'h08;
  localparam logic [CNT_W-1:0] BITS_HALF   = 7'h10;
  localparam logic [CNT_W-1:0] BITS_WORD   = 7'h20;
  localparam logic [CNT_W-1:0] BITS_DOUBLE = 7'h40;
  localparam logic [CNT_W-1:0] CNT_ONE     = 7'h01;

  // storage bytes use odd parity: byte plus check bit has an odd count
  localparam logic PARITY_GOOD = 1'b1;

  // ----------------------------------------------------------------
  // sequencer states, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_ADDS = 6'h02,
    S_MUL  = 6'h04,
    S_DIV  = 6'h08,
    S_CORR = 6'h10,
    S_FIX  = 6'h20
  } fpmd_state_type;

  localparam logic [DATA_W-1:0] RESULT_RST = 64'h0;

endpackage : fpmd_pkg

// file: fpmd_add_if.sv
// interface between the sequencer and the shared binary adder
`timescale 1ns/1ps
interface fpmd_add_if;
  logic [fpmd_pkg::ADD_W-1:0] a;
  logic [fpmd_pkg::ADD_W-1:0] b;
  logic                       sub;
  logic [fpmd_pkg::ADD_W-1:0] sum;
  logic                       carry;

  modport user  (output a, output b, output sub, input sum, input carry);
  modport adder (input a, input b, input sub, output sum, output carry);
endinterface : fpmd_add_if

// file: fpmd_adder.sv
// shared adder: true add, or add of the two's complement for subtraction
`timescale 1ns/1ps
module fpmd_adder (
  fpmd_add_if.adder port
);
  logic [fpmd_pkg::ADD_W:0]   full;
  logic [fpmd_pkg::ADD_W-1:0] b_eff;

  // [RQ2] invert then add one
  assign b_eff = port.sub ? ~port.b : port.b;
  // [RQ1] subtract by adding complement
  assign full  = {1'b0, port.a} + {1'b0, b_eff} + {{fpmd_pkg::ADD_W{1'b0}}, port.sub};

  assign port.sum   = full[fpmd_pkg::ADD_W-1:0];
  assign port.carry = full[fpmd_pkg::ADD_W];
endmodule : fpmd_adder

// file: fpmd_unit.sv
// fixed-point add, subtract, group-of-ones multiply and non-restoring divide
`timescale 1ns/1ps
module fpmd_unit (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        start_in,
  input  wire logic [1:0]  op_in,
  input  wire logic [1:0]  size_in,
  input  wire logic [63:0] operand_a_in,
  input  wire logic [63:0] operand_b_in,
  input  wire logic [7:0]  parity_a_in,
  input  wire logic [7:0]  parity_b_in,
  output logic             busy_out,
  output logic             done_out,
  output logic             div_zero_out,
  output logic             parity_irq_out,
  output logic [63:0]      result_hi_out,
  output logic [63:0]      result_lo_out
);

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    fpmd_pkg::fpmd_state_type st;
    fpmd_pkg::fpmd_op_type    opc;
    logic [6:0]               cnt;
    logic [6:0]               shamt;
    logic                     ingroup;
    logic                     over;
    logic                     neg_q;
    logic                     neg_r;
    logic [63:0]              mcand;
    logic [63:0]              mr;
    logic [64:0]              hi;
    logic [63:0]              lo;
    logic [65:0]              rem;
    logic [63:0]              quo;
    logic [63:0]              dvs;
    logic [63:0]              res_hi;
    logic [63:0]              res_lo;
    logic                     done;
    logic                     busy;
    logic                     par_irq;
    logic                     div_zero;
  } fpmd_regs_type;

  fpmd_regs_type q;
  fpmd_regs_type n;

  fpmd_add_if add_bus ();

  fpmd_adder u_adder (
    .port (add_bus.adder)
  );

  logic               accept;
  logic               par_bad;
  logic               div_by_zero;
  logic               mul_sub;
  logic               mul_op;
  logic [63:0]        opa;
  logic [63:0]        opb;
  logic signed [128:0] prod;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // [RQ11] field taken from leftmost bytes
  function automatic logic [63:0] fpmd_field(input logic [63:0] v, input logic [1:0] sz);
    case (sz)
      fpmd_pkg::SIZE_BYTE: fpmd_field = {{56{v[63]}}, v[63:56]};
      fpmd_pkg::SIZE_HALF: fpmd_field = {{48{v[63]}}, v[63:48]};
      fpmd_pkg::SIZE_WORD: fpmd_field = {{32{v[63]}}, v[63:32]};
      default:             fpmd_field = v;
    endcase
  endfunction : fpmd_field

  function automatic logic [6:0] fpmd_bits(input logic [1:0] sz);
    case (sz)
      fpmd_pkg::SIZE_BYTE: fpmd_bits = fpmd_pkg::BITS_BYTE;
      fpmd_pkg::SIZE_HALF: fpmd_bits = fpmd_pkg::BITS_HALF;
      fpmd_pkg::SIZE_WORD: fpmd_bits = fpmd_pkg::BITS_WORD;
      default:             fpmd_bits = fpmd_pkg::BITS_DOUBLE;
    endcase
  endfunction : fpmd_bits

  // [RQ2] invert and add one
  function automatic logic [63:0] fpmd_neg(input logic [63:0] v);
    fpmd_neg = ~v + 64'h1;
  endfunction : fpmd_neg

  function automatic logic [63:0] fpmd_mag(input logic [63:0] v);
    fpmd_mag = v[63] ? fpmd_neg(v) : v;
  endfunction : fpmd_mag

  assign accept      = (q.st == fpmd_pkg::S_IDLE) && start_in;
  assign opa         = fpmd_field(operand_a_in, size_in);
  assign opb         = fpmd_field(operand_b_in, size_in);
  assign div_by_zero = (opb == 64'h0);

  // ----------------------------------------------------------------
  // parity on operand bytes
  // ----------------------------------------------------------------
  // [RQ10] odd parity per byte
  always_comb begin
    logic [3:0] nbytes;
    nbytes  = 4'h1 << size_in;
    par_bad = 1'b0;
    for (int i = 0; i < fpmd_pkg::BYTES; i++) begin
      if (i < int'(nbytes)) begin
        if ((^{operand_a_in[63-8*i -: 8], parity_a_in[7-i]}) != fpmd_pkg::PARITY_GOOD) begin
          par_bad = 1'b1;
        end
        if ((^{operand_b_in[63-8*i -: 8], parity_b_in[7-i]}) != fpmd_pkg::PARITY_GOOD) begin
          par_bad = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // group-of-ones recoding of the current multiplier bit
  // ----------------------------------------------------------------
  // [RQ3] right-to-left group scan
  always_comb begin
    mul_sub = 1'b0;
    mul_op  = 1'b0;
    if (!q.ingroup) begin
      // [RQ4] first one subtracts, isolated one adds
      mul_op  = q.mr[0];
      mul_sub = q.mr[0] & q.mr[1];
    end else begin
      // [RQ5] zero inside subtracts, closing zero adds
      mul_op  = ~q.mr[0];
      mul_sub = ~q.mr[0] & q.mr[1];
    end
  end

  assign prod = $signed({q.hi, q.lo}) >>> q.shamt;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [64:0] s;
    s           = q.hi;
    n           = q;
    n.done      = 1'b0;
    n.par_irq   = 1'b0;
    add_bus.a   = '0;
    add_bus.b   = '0;
    add_bus.sub = 1'b0;
    case (q.st)
      fpmd_pkg::S_IDLE: begin
        if (start_in) begin
          n.opc      = fpmd_pkg::fpmd_op_type'(op_in);
          n.par_irq  = par_bad;
          n.div_zero = 1'b0;
          n.cnt      = fpmd_bits(size_in) - fpmd_pkg::CNT_ONE;
          n.shamt    = fpmd_pkg::BITS_DOUBLE - fpmd_bits(size_in);
          n.mcand    = opa;
          n.mr       = opb;
          n.hi       = '0;
          n.lo       = '0;
          n.ingroup  = 1'b0;
          n.over     = 1'b0;
          n.rem      = '0;
          n.busy     = 1'b1;
          case (fpmd_pkg::fpmd_op_type'(op_in))
            fpmd_pkg::FPMD_OP_MUL: n.st = fpmd_pkg::S_MUL;
            fpmd_pkg::FPMD_OP_DIV: begin
              // [RQ12] dividend left-aligned so it shifts past the divisor
              n.quo   = fpmd_mag(opa) << (fpmd_pkg::BITS_DOUBLE - fpmd_bits(size_in));
              n.dvs   = fpmd_mag(opb);
              n.neg_q = opa[63] ^ opb[63];
              n.neg_r = opa[63];
              if (div_by_zero) begin
                n.div_zero = 1'b1;
                n.done     = 1'b1;
                n.busy     = 1'b0;
              end else begin
                n.st = fpmd_pkg::S_DIV;
              end
            end
            default: n.st = fpmd_pkg::S_ADDS;
          endcase
        end
      end
      fpmd_pkg::S_ADDS: begin
        // [RQ1] subtract through complement add
        add_bus.a   = {{2{q.mcand[63]}}, q.mcand};
        add_bus.b   = {{2{q.mr[63]}}, q.mr};
        add_bus.sub = (q.opc == fpmd_pkg::FPMD_OP_SUB);
        n.res_lo    = add_bus.sum[63:0];
        n.res_hi    = {64{add_bus.sum[64]}};
        n.done      = 1'b1;
        n.busy      = 1'b0;
        n.st        = fpmd_pkg::S_IDLE;
      end
      fpmd_pkg::S_MUL: begin
        add_bus.a   = {q.hi[64], q.hi};
        add_bus.b   = {{2{q.mcand[63]}}, q.mcand};
        add_bus.sub = mul_sub;
        if (mul_op) begin
          s = add_bus.sum[64:0];
        end
        if (!q.ingroup && q.mr[0] && q.mr[1]) begin
          n.ingroup = 1'b1;
        end else if (q.ingroup && !q.mr[0] && !q.mr[1]) begin
          n.ingroup = 1'b0;
        end
        // sign bit copies in, so the last step sees the sign as its left neighbour
        n.hi  = {s[64], s[64:1]};
        n.lo  = {s[0], q.lo[63:1]};
        n.mr  = {q.mr[63], q.mr[63:1]};
        n.cnt = q.cnt - fpmd_pkg::CNT_ONE;
        if (q.cnt == 7'h00) begin
          n.st = fpmd_pkg::S_FIX;
        end
      end
      fpmd_pkg::S_DIV: begin
        // [RQ12] after overdraw, add back and reduce in one cycle
        add_bus.a   = {q.rem[64:0], q.quo[63]};
        add_bus.b   = {2'b00, q.dvs};
        add_bus.sub = ~q.over;
        n.rem       = add_bus.sum;
        // [RQ9] carry-out gives quotient one
        n.quo       = {q.quo[62:0], add_bus.carry};
        // [RQ7] no carry marks overdraw
        n.over      = ~add_bus.carry;
        n.cnt       = q.cnt - fpmd_pkg::CNT_ONE;
        if (q.cnt == 7'h00) begin
          // [RQ8] trailing overdraw needs correction
          n.st = add_bus.carry ? fpmd_pkg::S_FIX : fpmd_pkg::S_CORR;
        end
      end
      fpmd_pkg::S_CORR: begin
        // [RQ8] add divisor back
        add_bus.a   = q.rem;
        add_bus.b   = {2'b00, q.dvs};
        add_bus.sub = 1'b0;
        n.rem       = add_bus.sum;
        n.over      = 1'b0;
        n.st        = fpmd_pkg::S_FIX;
      end
      fpmd_pkg::S_FIX: begin
        // [RQ13] result latched, held until next start
        if (q.opc == fpmd_pkg::FPMD_OP_MUL) begin
          n.res_hi = prod[127:64];
          n.res_lo = prod[63:0];
        end else begin
          // [RQ6] signs restored from the original operands
          n.res_lo = q.neg_q ? fpmd_neg(q.quo) : q.quo;
          n.res_hi = q.neg_r ? fpmd_neg(q.rem[63:0]) : q.rem[63:0];
        end
        n.done = 1'b1;
        n.busy = 1'b0;
        n.st   = fpmd_pkg::S_IDLE;
      end
      default: begin
        n.st   = fpmd_pkg::S_IDLE;
        n.busy = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // [RQ14] reset clears datapath and counter
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      q          <= '0;
      q.st       <= fpmd_pkg::S_IDLE;
      q.opc      <= fpmd_pkg::FPMD_OP_ADD;
      q.res_hi   <= fpmd_pkg::RESULT_RST;
      q.res_lo   <= fpmd_pkg::RESULT_RST;
    end else begin
      q <= n;
    end
  end

  assign busy_out       = q.busy;
  assign done_out       = q.done;
  assign div_zero_out   = q.div_zero;
  assign parity_irq_out = q.par_irq;
  assign result_hi_out  = q.res_hi;
  assign result_lo_out  = q.res_lo;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  sequence s_mul_start;
    accept && (op_in == fpmd_pkg::FPMD_OP_MUL);
  endsequence

  sequence s_last_overdraw;
    (q.st == fpmd_pkg::S_DIV) && (q.cnt == 7'h00) && !add_bus.carry;
  endsequence

  sequence s_correct_then_fix;
    (q.st == fpmd_pkg::S_CORR) ##1 (q.st == fpmd_pkg::S_FIX);
  endsequence

  property p_sub_by_complement;
    (q.st == fpmd_pkg::S_ADDS) && (q.opc == fpmd_pkg::FPMD_OP_SUB)
      |=> result_lo_out == ($past(q.mcand) - $past(q.mr));
  endproperty
  a_sub_by_complement: assert property (p_sub_by_complement) // [RQ1]
    else $error("subtract result wrong");

  property p_complement_form;
    (q.st == fpmd_pkg::S_DIV) && !q.over
      |-> add_bus.sum == (add_bus.a + ~add_bus.b + 66'h1);
  endproperty
  a_complement_form: assert property (p_complement_form) // [RQ2]
    else $error("reduction not done by complement add");

  property p_group_opens;
    (q.st == fpmd_pkg::S_MUL) && !q.ingroup && q.mr[0] && q.mr[1]
      |-> (mul_op && mul_sub) ##1 q.ingroup;
  endproperty
  a_group_opens: assert property (p_group_opens) // [RQ3]
    else $error("group start did not subtract");

  property p_inside_shift;
    (q.st == fpmd_pkg::S_MUL) && q.ingroup && q.mr[0]
      |=> q.hi == {$past(q.hi[64]), $past(q.hi[64:1])};
  endproperty
  a_inside_shift: assert property (p_inside_shift) // [RQ4]
    else $error("one inside group was not shift only");

  property p_group_closes;
    (q.st == fpmd_pkg::S_MUL) && q.ingroup && !q.mr[0] && !q.mr[1]
      |-> (mul_op && !mul_sub) ##1 !q.ingroup;
  endproperty
  a_group_closes: assert property (p_group_closes) // [RQ5]
    else $error("closing zero did not add");

  property p_div_success;
    (q.st == fpmd_pkg::S_DIV) && add_bus.carry |=> q.quo[0] && !q.over;
  endproperty
  a_div_success: assert property (p_div_success) // [RQ9]
    else $error("carry-out did not give quotient one");

  property p_div_overdraw;
    (q.st == fpmd_pkg::S_DIV) && !add_bus.carry |=> !q.quo[0] && q.over;
  endproperty
  a_div_overdraw: assert property (p_div_overdraw) // [RQ7]
    else $error("overdraw gave quotient one");

  property p_merged_correction;
    (q.st == fpmd_pkg::S_DIV) && q.over |-> !add_bus.sub;
  endproperty
  a_merged_correction: assert property (p_merged_correction) // [RQ12]
    else $error("step after overdraw did not add divisor");

  property p_final_correction;
    s_last_overdraw |=> s_correct_then_fix;
  endproperty
  a_final_correction: assert property (p_final_correction) // [RQ8]
    else $error("trailing overdraw not corrected");

  property p_parity_irq;
    accept && par_bad |=> parity_irq_out ##1 !parity_irq_out;
  endproperty
  a_parity_irq: assert property (p_parity_irq) // [RQ10]
    else $error("parity error not flagged");

  property p_byte_length;
    s_mul_start and (size_in == fpmd_pkg::SIZE_BYTE)
      |=> (q.cnt == 7'h07) ##8 (q.st == fpmd_pkg::S_FIX);
  endproperty
  a_byte_length: assert property (p_byte_length) // [RQ11]
    else $error("byte multiply step count wrong");

  property p_done_pulse;
    done_out |=> !done_out;
  endproperty
  a_done_pulse: assert property (p_done_pulse) // [RQ13]
    else $error("done longer than one cycle");

  property p_result_hold;
    q.st == fpmd_pkg::S_IDLE |=> $stable(result_lo_out) && $stable(result_hi_out);
  endproperty
  a_result_hold: assert property (p_result_hold) // [RQ13]
    else $error("result changed while idle");

  property p_mul_completes;
    s_mul_start |=> busy_out ##[1:70] done_out;
  endproperty
  a_mul_completes: assert property (p_mul_completes) // [RQ13]
    else $error("multiply did not complete in time");

  property p_idle_waits;
    (q.st == fpmd_pkg::S_IDLE) && !start_in |=> (q.st == fpmd_pkg::S_IDLE) && !busy_out;
  endproperty
  a_idle_waits: assert property (p_idle_waits) // [RQ14]
    else $error("left idle without start");

endmodule : fpmd_unit

// file: fpmd_seq_model.sv
// sequencer partner model: one-cycle start and take-to-done count
`timescale 1ns/1ps
module fpmd_seq_model (
  input  wire logic       clk_in,
  input  wire logic       resetn_in,
  input  wire logic       go_in,
  input  wire logic       done_in,
  output logic            start_out,
  output logic [7:0]      lat_out
);
  logic run;

  // ------------------------------------------------------------
  // start pulse and latency count
  // ------------------------------------------------------------
  // one-cycle start pulse
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      start_out <= 1'b0;
      run       <= 1'b0;
      lat_out   <= 8'h00;
    end else begin
      start_out <= go_in;
      if (start_out) begin
        run     <= 1'b1;
        lat_out <= 8'h00;
      end else if (run && done_in) begin
        run <= 1'b0;
      end else if (run) begin
        lat_out <= lat_out + 8'h01;
      end
    end
  end
endmodule : fpmd_seq_model

// file: tb_fixed_point_mul_div_unit.sv
// self-checking bench for the fixed-point mul/div unit
`timescale 1ns/1ps
module tb_fixed_point_mul_div_unit;
  logic        clk_in;
  logic        resetn_in;
  logic        go;
  logic        start;
  logic [1:0]  op;
  logic [1:0]  size;
  logic [63:0] a;
  logic [63:0] b;
  logic [7:0]  pa;
  logic [7:0]  pb;
  logic        busy;
  logic        done;
  logic        dz;
  logic        irq;
  logic [63:0] hi;
  logic [63:0] lo;
  logic [7:0]  lat;
  logic [63:0] last_h;
  logic [63:0] last_l;
  int          failures = 0;
  int          samples_checked = 0;

  fpmd_unit fpmd_unit_i (.clk_in(clk_in), .resetn_in(resetn_in), .start_in(start),
    .op_in(op), .size_in(size), .operand_a_in(a), .operand_b_in(b), .parity_a_in(pa),
    .parity_b_in(pb), .busy_out(busy), .done_out(done), .div_zero_out(dz),
    .parity_irq_out(irq), .result_hi_out(hi), .result_lo_out(lo));

  fpmd_seq_model fpmd_seq_model_i (.clk_in(clk_in), .resetn_in(resetn_in), .go_in(go),
    .done_in(done), .start_out(start), .lat_out(lat));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [63:0] fld(input logic [63:0] v, input logic [1:0] s);
    int sh;
    sh = 64 - (8 << s);
    return $signed(v << sh) >>> sh;
  endfunction : fld

  function automatic logic [7:0] par(input logic [63:0] v);
    for (int i = 0; i < 8; i++) par[i] = ~^v[8*i+:8];
  endfunction : par

  task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
    samples_checked++;
    if (g !== x) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic set(input logic [1:0] o, s, input logic [63:0] fa, fb, input logic [7:0] f);
    int sh;
    sh = 64 - (8 << s);
    op <= o;
    size <= s;
    a <= fa << sh;
    b <= fb << sh;
    pa <= par(fa << sh) ^ f;
    pb <= par(fb << sh);
  endtask : set

  task automatic run(input logic [1:0] o, s, input logic [63:0] fa, fb, input logic [7:0] f);
    logic [63:0] ea, eb, xh, xl;
    int xlat, irqs, ilat, bb;
    logic bad;
    ea = fld(fa, s);
    eb = fld(fb, s);
    xh = last_h;
    xl = last_l;
    // done follows the taking edge by one edge for add and subtract
    xlat = 1;
    // only check bits of bytes inside the field count
    bad = (f & ~(8'hFF >> (1 << s))) != 8'h00;
    case (o)
      2'h0: xl = ea + eb;
      2'h1: xl = ea + (~eb + 64'h1);
      2'h2: {xh, xl} = $signed({{64{ea[63]}}, ea}) * $signed({{64{eb[63]}}, eb});
      default: if (eb != 64'h0) begin
        xl = $signed(ea) / $signed(eb);
        xh = $signed(ea) % $signed(eb);
      end
    endcase
    if (o < 2'h2) xh = {64{xl[63]}};
    // zero divisor answers at the taking edge itself; a trailing overdraw costs one edge
    if (o == 2'h3 && eb == 64'h0) xlat = 0;
    else if (o[1]) xlat = (8 << s) + 1 + ((o[0] && !xl[0]) ? 1 : 0);
    @(posedge clk_in);
    set(o, s, fa, fb, f);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    @(posedge clk_in);
    irqs = 0;
    ilat = 0;
    bb = 0;
    for (int i = 0; i < 300; i++) begin
      @(negedge clk_in);
      if (irq === 1'b1) begin
        irqs++;
        // irq belongs in the first cycle after taking, while lat is still 0
        ilat = lat + 1;
      end
      if (done === 1'b1) break;
      if (lat != 8'h00 && busy !== 1'b1) bb++;
    end
    chk("latency", xlat, lat);
    chk("result_hi", xh, hi);
    chk("result_lo", xl, lo);
    chk("div_zero", {63'h0, o == 2'h3 && eb == 64'h0}, dz);
    chk("parity_irq_count", bad, irqs);
    chk("parity_irq_time", bad, ilat);
    chk("busy_gaps", 0, bb);
    @(negedge clk_in);
    chk("done_pulse", 0, done);
    last_h = xh;
    last_l = xl;
  endtask : run

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_addsub();
    for (int s = 0; s < 4; s++) begin
      run(2'h0, s[1:0], -64'd100, 64'd27, 8'h00);
      run(2'h1, s[1:0], 64'd15, 64'd7, 8'h00);
      run(2'h1, s[1:0], 64'd7, 64'd15, 8'h00);
    end
    $display("add and subtract finished");
  endtask : t_addsub

  task automatic t_mul();
    for (int s = 0; s < 4; s++) begin
      run(2'h2, s[1:0], 64'd26, 64'd19, 8'h00);
      run(2'h2, s[1:0], -64'd5, 64'h2B, 8'h00);
      run(2'h2, s[1:0], 64'd37, -64'd86, 8'h00);
    end
    run(2'h2, 2'h0, -64'd128, -64'd128, 8'h00);
    run(2'h2, 2'h3, 64'h7FFF_FFFF_FFFF_FFFF, 64'hB6DB_6DB6_DB6D_B6DB, 8'h00);
    $display("multiply finished");
  endtask : t_mul

  task automatic t_div();
    run(2'h3, 2'h1, 64'd269, 64'd7, 8'h00);
    run(2'h3, 2'h1, -64'd269, 64'd7, 8'h00);
    run(2'h3, 2'h0, 64'd100, -64'd7, 8'h00);
    run(2'h3, 2'h2, 64'd12, 64'd3, 8'h00);
    run(2'h3, 2'h3, 64'h7FFF_FFFF_FFFF_FFFF, 64'd10, 8'h00);
    run(2'h3, 2'h2, 64'd5, 64'd0, 8'h00);
    run(2'h3, 2'h0, 64'd1, 64'd2, 8'h00);
    $display("divide finished");
  endtask : t_div

  task automatic t_parity();
    run(2'h0, 2'h2, 64'd5, 64'd6, 8'h40);
    run(2'h0, 2'h0, 64'd5, 64'd6, 8'h01);
    run(2'h2, 2'h3, 64'd3, 64'd4, 8'h01);
    $display("parity finished");
  endtask : t_parity

  task automatic t_refuse();
    int dn;
    @(posedge clk_in);
    set(2'h0, 2'h0, 64'd3, 64'd4, 8'h00);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    // second start lands in the done cycle
    @(posedge clk_in);
    set(2'h1, 2'h0, 64'd9, 64'd2, 8'h00);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    dn = 0;
    repeat (8) begin
      @(negedge clk_in);
      if (done === 1'b1) dn++;
    end
    chk("back_to_back_dones", 2, dn);
    chk("result_lo", 64'd7, lo);
    @(posedge clk_in);
    set(2'h2, 2'h0, 64'd3, 64'd5, 8'h00);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (4) @(posedge clk_in);
    set(2'h0, 2'h0, 64'd1, 64'd1, 8'h00);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    dn = 0;
    repeat (16) begin
      @(negedge clk_in);
      if (done === 1'b1) dn++;
    end
    chk("refused_dones", 1, dn);
    chk("result_lo", 64'd15, lo);
    $display("refuse and back-to-back finished");
  endtask : t_refuse

  task automatic t_reset();
    int dn;
    @(posedge clk_in);
    set(2'h2, 2'h3, 64'd7, 64'd9, 8'h00);
    go <= 1'b1;
    @(posedge clk_in);
    go <= 1'b0;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1'b0;
    @(negedge clk_in);
    chk("reset_flags", 0, {busy, done, dz, irq});
    chk("reset_hi", fpmd_pkg::RESULT_RST, hi);
    chk("reset_lo", fpmd_pkg::RESULT_RST, lo);
    repeat (3) @(posedge clk_in);
    resetn_in <= 1'b1;
    dn = 0;
    repeat (80) begin
      @(negedge clk_in);
      if (done === 1'b1 || busy === 1'b1) dn++;
    end
    chk("idle_after_reset", 0, dn);
    run(2'h0, 2'h0, 64'd2, 64'd3, 8'h00);
    $display("reset finished");
  endtask : t_reset

  task automatic summarize();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  // ------------------------------------------------------------
  // clock, sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    resetn_in = 1'b0;
    go = 1'b0;
    op = 2'h0;
    size = 2'h0;
    a = 64'h0;
    b = 64'h0;
    pa = 8'h00;
    pb = 8'h00;
    last_h = 64'h0;
    last_l = 64'h0;
    repeat (6) @(posedge clk_in);
    resetn_in <= 1'b1;
    t_addsub();
    t_mul();
    t_div();
    t_parity();
    t_refuse();
    t_reset();
    summarize();
  end

  // whole run is about a thousand cycles; allow ample margin
  initial begin
    #400000;
    failures++;
    $display("BAD watchdog expected finish seen hang");
    summarize();
  end
endmodule : tb_fixed_point_mul_div_unit
